// File: verilog/reset_and_boot_vector_control.sv
`timescale 1ns/1ps
module reset_and_boot_vector_control #(
    parameter logic [15:0] BOOT_VECTOR = reset_ctrl_pkg::BOOT_VECTOR_DEF,
    parameter int          PORT_WIDTH  = 8
) (
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire logic                          powerOnReq,
    input  wire logic                          external_reset_pin_n_in,
    input  wire logic                          compareReq,
    input  wire logic                          softwareReq,
    input  wire logic                          supplyReq,
    input  wire logic                          watchdogReq,
    input  wire logic                          missClkReq,
    input  wire logic                          flashErrReq,
    input  wire logic                          usbResetReq,
    input  wire logic [7:0]                    bootSignature,
    output logic                               external_reset_pin_n_out,
    output logic                               external_reset_pin_n_oe_n,
    output reset_ctrl_pkg::reset_ctl_t         resetCtl,
    output logic [PORT_WIDTH-1:0]              portLatch,
    output logic [PORT_WIDTH-1:0]              portOpenDrain,
    output reset_ctrl_pkg::src_vec_t           lastSource,
    output logic                               ramWriteBlock
);
    import reset_ctrl_pkg::*;

    src_vec_t   rawReq;
    src_vec_t   syncReq;
    src_vec_t   latched_reg;
    seq_state_t state_reg;
    seq_state_t state_next;
    logic       anyReq;
    logic       pinDrive;
    src_vec_t   pinMask;
    src_vec_t   maskedReq;
    src_vec_t   heldReq;
    logic [SYNC_STAGES-1:0] echoHist_reg;

    // Gather sources; the pin is active low so invert before syncing
    always_comb begin
        rawReq               = '0;
        rawReq[SRC_POWER_ON] = powerOnReq;
        rawReq[SRC_PIN]      = ~external_reset_pin_n_in;
        rawReq[SRC_COMPARE]  = compareReq;
        rawReq[SRC_SOFTWARE] = softwareReq;
        rawReq[SRC_SUPPLY]   = supplyReq;
        rawReq[SRC_WATCHDOG] = watchdogReq;
        rawReq[SRC_MISSCLK]  = missClkReq;
        rawReq[SRC_FLASH]    = flashErrReq;
        rawReq[SRC_USB]      = usbResetReq;
    end

    // Every source crosses two flops before use
    reset_sync #(
        .WIDTH  (SRC_COUNT),
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .clk     (clk),
        .resetn  (resetn),
        .asyncIn (rawReq),
        .syncOut (syncReq)
    );

    // Our own pin drive reads back as a pin request. The echo trails the drive
    // by the synchroniser depth, so the mask is stretched by that many cycles;
    // otherwise the echo would re-enter reset right after a power-on exit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            echoHist_reg <= '0;
        end else begin
            echoHist_reg <= {echoHist_reg[SYNC_STAGES-2:0], pinDrive};
        end
    end

    // Limitation: a real pin press inside that short tail is not seen
    assign pinDrive  = ~external_reset_pin_n_oe_n;
    assign pinMask   = (pinDrive | (|echoHist_reg)) ? (src_vec_t'(1) << SRC_PIN) : '0;
    assign maskedReq = syncReq & ~pinMask;
    assign anyReq    = |maskedReq;
    // History from an earlier reset must not act once we are running
    assign heldReq   = (state_reg == ST_RUN) ? '0 : latched_reg;

    // Release only after all sources are gone and one clean sample passes
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RESET:  if (!anyReq) state_next = ST_SAMPLE;
            ST_SAMPLE: state_next = anyReq ? ST_RESET : ST_RUN;
            ST_RUN:    if (anyReq) state_next = ST_RESET;
            default:   state_next = ST_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Record which sources caused the latest reset; a reset entered from run replaces the history
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latched_reg <= '0;
            lastSource  <= '0;
        end else begin
            if (state_reg == ST_RUN && anyReq) begin
                latched_reg <= maskedReq;
            end else if (state_reg != ST_RUN) begin
                latched_reg <= latched_reg | maskedReq;
            end
            if (state_next == ST_RUN && state_reg == ST_SAMPLE) begin
                lastSource <= latched_reg;
            end
        end
    end

    // Reset pin: drive low only for power-on and supply monitor resets
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            external_reset_pin_n_out  <= 1'b0;
            external_reset_pin_n_oe_n <= 1'b1;
        end else begin
            external_reset_pin_n_out <= 1'b0;
            if (state_next != ST_RUN && (syncReq[SRC_POWER_ON] || syncReq[SRC_SUPPLY] ||
                heldReq[SRC_POWER_ON] || heldReq[SRC_SUPPLY])) begin
                external_reset_pin_n_oe_n <= 1'b0;
            end else begin
                external_reset_pin_n_oe_n <= 1'b1;
            end
        end
    end

    // Core and peripheral controls, all from flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resetCtl.coreHalt       <= 1'b1;
            resetCtl.warmResetN     <= 1'b0;
            resetCtl.coldResetN     <= 1'b0;
            resetCtl.intDisable     <= 1'b1;
            resetCtl.timerDisable   <= 1'b1;
            resetCtl.pullupEnable   <= 1'b1;
            resetCtl.watchdogEnable <= 1'b0;
            resetCtl.clkSel         <= CLK_SEL_INTERNAL;
            resetCtl.startVector    <= RESET_VECTOR;
            resetCtl.pcLoad         <= 1'b0;
        end else begin
            resetCtl.coreHalt     <= (state_next != ST_RUN);
            resetCtl.warmResetN   <= (state_next == ST_RUN);
            // Cold domain only resets on power-on; other types keep it
            resetCtl.coldResetN   <= ~(syncReq[SRC_POWER_ON] |
                                      (heldReq[SRC_POWER_ON] & (state_next != ST_RUN)));
            resetCtl.intDisable   <= (state_next != ST_RUN);
            resetCtl.timerDisable <= (state_next != ST_RUN);
            resetCtl.pullupEnable <= 1'b1;
            resetCtl.pcLoad       <= (state_reg == ST_SAMPLE && state_next == ST_RUN);
            if (state_next != ST_RUN) begin
                resetCtl.watchdogEnable <= 1'b1;
                resetCtl.clkSel         <= CLK_SEL_INTERNAL;
                // Signature is compared exactly; anything else is no loader
                resetCtl.startVector    <= (bootSignature == BOOT_SIG_OK) ? BOOT_VECTOR
                                                                          : RESET_VECTOR;
            end
        end
    end

    // Port latches high, open-drain, while in reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            portLatch     <= PORT_WIDTH'(PORT_LATCH_RESET);
            portOpenDrain <= '1;
        end else begin
            portLatch     <= PORT_WIDTH'(PORT_LATCH_RESET);
            portOpenDrain <= '1;
        end
    end

    // RAM is never cleared; only writes are blocked while core is held
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ramWriteBlock <= 1'b1;
        end else begin
            ramWriteBlock <= (state_next != ST_RUN);
        end
    end
endmodule

// File: verilog/reset_ctrl_pkg.sv
// What this block does
// - Hold core halted while reset is active
// - Load reset values; keep power-on-only bits
// - Port latches forced to one, open-drain
// - Weak pullups on during and after reset
// - Disable interrupts and timers in reset
// - Never touch data RAM during reset
// - Drive reset pin low for power/supply resets
// - Load program counter with start vector, select internal oscillator
// - Watchdog enabled when leaving any reset
// - Nine reset sources enter reset
// - Signature byte 0xa5 marks bootloader present
// - Any other signature means no bootloader
// - Bootloader present: start at bootloader vector
// - No bootloader: start at address zero
package reset_ctrl_pkg;
    localparam int          SRC_COUNT     = 9;
    localparam int          SRC_POWER_ON  = 0;
    localparam int          SRC_PIN       = 1;
    localparam int          SRC_COMPARE   = 2;
    localparam int          SRC_SOFTWARE  = 3;
    localparam int          SRC_SUPPLY    = 4;
    localparam int          SRC_WATCHDOG  = 5;
    localparam int          SRC_MISSCLK   = 6;
    localparam int          SRC_FLASH     = 7;
    localparam int          SRC_USB       = 8;
    localparam logic [7:0]  BOOT_SIG_OK   = 8'ha5;
    localparam logic [15:0] RESET_VECTOR  = 16'h0000;
    localparam logic [15:0] BOOT_VECTOR_DEF = 16'h3a00;
    localparam logic [7:0]  PORT_LATCH_RESET = 8'hff;
    localparam logic [1:0]  CLK_SEL_INTERNAL = 2'h0;
    localparam int          SYNC_STAGES   = 2;

    typedef logic [SRC_COUNT-1:0] src_vec_t;

    typedef struct packed {
        logic        coreHalt;
        logic        warmResetN;
        logic        coldResetN;
        logic        intDisable;
        logic        timerDisable;
        logic        pullupEnable;
        logic        watchdogEnable;
        logic [1:0]  clkSel;
        logic [15:0] startVector;
        logic        pcLoad;
    } reset_ctl_t;

    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_RUN   = 3'b100
    } seq_state_t;
endpackage

// File: verilog/reset_sync.sv
`timescale 1ns/1ps
module reset_sync #(
    parameter int WIDTH  = 1,
    parameter int STAGES = 2
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage_reg [STAGES];

    // First stage is read only by the next stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_reg[i] <= '0;
            end
        end else begin
            stage_reg[0] <= asyncIn;
            for (int i = 1; i < STAGES; i++) begin
                stage_reg[i] <= stage_reg[i-1];
            end
        end
    end

    assign syncOut = stage_reg[STAGES-1];
endmodule

// File: testbench/reset_and_boot_vector_control_properties.sv
`timescale 1ns/1ps
module reset_and_boot_vector_control_properties #(
    parameter logic [15:0] BOOT_VECTOR = reset_ctrl_pkg::BOOT_VECTOR_DEF,
    parameter int          PORT_WIDTH  = 8
) (
    input wire logic                      clk,
    input wire logic                      resetn,
    input wire logic                      powerOnReq,
    input wire logic                      external_reset_pin_n_in,
    input wire logic                      compareReq,
    input wire logic                      softwareReq,
    input wire logic                      supplyReq,
    input wire logic                      watchdogReq,
    input wire logic                      missClkReq,
    input wire logic                      flashErrReq,
    input wire logic                      usbResetReq,
    input wire logic [7:0]                bootSignature,
    input wire logic                      external_reset_pin_n_oe_n,
    input wire reset_ctrl_pkg::reset_ctl_t resetCtl,
    input wire logic [PORT_WIDTH-1:0]     portLatch,
    input wire logic [PORT_WIDTH-1:0]     portOpenDrain,
    input wire logic                      ramWriteBlock
);
    import reset_ctrl_pkg::*;
    logic reqAny;
    // Pin readback counts only while we are not pulling it ourselves
    assign reqAny = powerOnReq | compareReq | softwareReq | supplyReq | watchdogReq | missClkReq
                  | flashErrReq | usbResetReq | (~external_reset_pin_n_in & external_reset_pin_n_oe_n);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence sExit; $fell(resetCtl.coreHalt); endsequence
    sequence sQuiet; !reqAny [*7]; endsequence
    chk_halt_on_req: assert property (reqAny |-> ##[1:4] resetCtl.coreHalt)
        else $error("core not halted after request");
    chk_halt_holds: assert property (reqAny [*4] |-> resetCtl.coreHalt)
        else $error("reset left while a source is active");
    chk_quiet_run: assert property (sQuiet |-> !resetCtl.coreHalt)
        else $error("core still halted with no source");
    chk_pin_drive: assert property ((powerOnReq | supplyReq) |-> ##[1:4] !external_reset_pin_n_oe_n)
        else $error("reset pin not driven");
    chk_pin_only_halt: assert property (!external_reset_pin_n_oe_n |-> resetCtl.coreHalt)
        else $error("reset pin driven outside reset");
    chk_exit_vector: assert property (sExit |-> resetCtl.startVector ==
        (($past(bootSignature) == BOOT_SIG_OK) ? BOOT_VECTOR : RESET_VECTOR)) else $error("bad start vector");
    chk_exit_state: assert property (sExit |-> resetCtl.pcLoad && resetCtl.watchdogEnable &&
        resetCtl.clkSel == CLK_SEL_INTERNAL ##1 !resetCtl.pcLoad) else $error("bad exit state");
    chk_reset_outs: assert property (resetCtl.coreHalt [*2] |-> resetCtl.intDisable &&
        resetCtl.timerDisable && ramWriteBlock && !resetCtl.warmResetN) else $error("reset outputs wrong");
    chk_ports_safe: assert property (portLatch == '1 && portOpenDrain == '1 && resetCtl.pullupEnable)
        else $error("port state wrong");
endmodule
bind reset_and_boot_vector_control reset_and_boot_vector_control_properties #(
    .BOOT_VECTOR(BOOT_VECTOR), .PORT_WIDTH(PORT_WIDTH)) props_i (.clk, .resetn, .powerOnReq,
    .external_reset_pin_n_in, .compareReq, .softwareReq, .supplyReq, .watchdogReq, .missClkReq,
    .flashErrReq, .usbResetReq, .bootSignature, .external_reset_pin_n_oe_n, .resetCtl, .portLatch,
    .portOpenDrain, .ramWriteBlock);

// File: testbench/reset_pin_model.sv
`timescale 1ns/1ps
module reset_pin_model (
    input  wire logic oeN,
    input  wire logic pinOut,
    input  wire logic pullLow,
    output logic      pinLevel
);
    // Pulled-up wire: the block or an outside switch may pull it low
    assign pinLevel = ((~oeN & ~pinOut) | pullLow) ? 1'b0 : 1'b1;
endmodule

// File: testbench/reset_and_boot_vector_control_tb_top.sv
`timescale 1ns/1ps
module reset_and_boot_vector_control_tb_top;
    import reset_ctrl_pkg::*;
    localparam logic [15:0] BV = 16'h1234;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic [8:0] req = 9'h000;
    logic [7:0] bootSignature = 8'h00;
    logic       pinLevel, external_reset_pin_n_out, external_reset_pin_n_oe_n, ramWriteBlock;
    reset_ctl_t resetCtl;
    logic [7:0] portLatch, portOpenDrain;
    src_vec_t   lastSource;
    int         fail_count = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         seed = 32'h9a485fb0;
    always #2 clk = ~clk;
    reset_and_boot_vector_control #(.BOOT_VECTOR(BV)) reset_and_boot_vector_control_i (.clk, .resetn,
        .powerOnReq(req[0]), .external_reset_pin_n_in(pinLevel), .compareReq(req[2]), .softwareReq(req[3]),
        .supplyReq(req[4]), .watchdogReq(req[5]), .missClkReq(req[6]), .flashErrReq(req[7]),
        .usbResetReq(req[8]), .bootSignature, .external_reset_pin_n_out, .external_reset_pin_n_oe_n,
        .resetCtl, .portLatch, .portOpenDrain, .lastSource, .ramWriteBlock);
    reset_pin_model reset_pin_model_i (.oeN(external_reset_pin_n_oe_n), .pinOut(external_reset_pin_n_out),
        .pullLow(req[1]), .pinLevel);
    // Expected start address, worked out from the signature alone
    function automatic logic [15:0] expVec(logic [7:0] s);
        return (s === BOOT_SIG_OK) ? BV : RESET_VECTOR;
    endfunction
    task automatic cmp(logic [15:0] got, logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Bounded wait; a hang shows up as a failed compare afterwards
    task automatic waitHalt(logic v);
        for (int n = 0; n < 12 && resetCtl.coreHalt !== v; n++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic hit(int s, int len, logic [7:0] sig);
        bootSignature <= sig;
        req[s] <= 1'b1;
        waitHalt(1'b1);
        cmp(resetCtl.coreHalt, 1'b1);
        cmp(external_reset_pin_n_oe_n, (s == 0 || s == 4) ? 1'b0 : 1'b1);
        cmp(resetCtl.coldResetN, s != 0);
        cmp({resetCtl.intDisable, resetCtl.timerDisable, ramWriteBlock}, 3'b111);
        cmp({resetCtl.pullupEnable, portLatch & portOpenDrain}, 9'h1ff);
        repeat (len) @(posedge clk);
        req[s] <= 1'b0;
        waitHalt(1'b0);
        cmp(resetCtl.startVector, expVec(sig));
        cmp({resetCtl.pcLoad, resetCtl.clkSel}, {1'b1, CLK_SEL_INTERNAL});
        cmp({resetCtl.watchdogEnable, external_reset_pin_n_oe_n}, 2'b11);
        cmp(lastSource, 9'h001 << s);
        @(posedge clk);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        logic [7:0] sig;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        waitHalt(1'b0);
        @(posedge clk);
        // Every source, signature valid, one-off corner and random
        for (int i = 0; i < 27; i++) begin
            sig = (i % 3 == 0) ? BOOT_SIG_OK : (i % 3 == 1) ? 8'ha4 : 8'($random(seed));
            hit(i % 9, 1 + int'($unsigned($random(seed)) % 6), sig);
        end
        // Overlapping sources: release of one must not end reset
        req[3] <= 1'b1;
        req[5] <= 1'b1;
        waitHalt(1'b1);
        @(posedge clk);
        req[3] <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        cmp(resetCtl.coreHalt, 1'b1);
        @(posedge clk);
        req[5] <= 1'b0;
        waitHalt(1'b0);
        cmp(lastSource, 9'h028);
        @(posedge clk);
        // Master reset in mid-run
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        waitHalt(1'b0);
        cmp(resetCtl.startVector, expVec(bootSignature));
        stop_test();
    end
endmodule
